// [shared/agsc_pkg.sv]
package agsc_pkg;

   // ******************************************************************
   // Widths and fixed register indices.
   // ******************************************************************
   localparam int unsigned DATA_W = 16;  // Data word and address width.
   localparam int unsigned SEL_W = 4;  // Working register select width.
   localparam int unsigned NREGS = 16;  // Number of working registers.
   localparam int unsigned NEAR_W = 13;  // Direct address field width.
   localparam int unsigned LIT_W = 10;  // Widest short literal.
   localparam int unsigned LIT5_W = 5;  // Narrow literal width.
   localparam int unsigned PC_W = 23;  // Program counter width.
   localparam int unsigned PC_HI_W = 7;  // Upper program counter part.
   localparam int unsigned BYTE_W = 8;  // Status low byte width.
   localparam int unsigned MODE_W = 3;  // Addressing mode code width.

   localparam logic [SEL_W-1:0] SP_IDX = 4'hF;  // Stack pointer register.
   localparam logic [SEL_W-1:0] DEFAULT_WORKING_REGISTER_IDX = 4'h0;  // Default working register.

   // ******************************************************************
   // Stack constants.
   // ******************************************************************
   localparam logic [DATA_W-1:0] STK_STEP = 16'h0002;  // One word in bytes.
   localparam logic [DATA_W-1:0] STK_FLOOR = 16'h0800;  // Lowest legal stack address.
   localparam logic [DATA_W-1:0] WORD_MASK = 16'hFFFE;  // Clears the byte bit.
   localparam logic [DATA_W-1:0] REG_RST = 16'h0000;  // Working register reset value.

   // ******************************************************************
   // Secure RAM windows (placement of the protected segments).
   // ******************************************************************
   localparam logic [DATA_W-1:0] BOOT_RAM_LO = 16'h0800;  // Boot segment first byte.
   localparam logic [DATA_W-1:0] BOOT_RAM_HI = 16'h08FF;  // Boot segment last byte.
   localparam logic [DATA_W-1:0] SEC_RAM_LO = 16'h0900;  // Secure segment first byte.
   localparam logic [DATA_W-1:0] SEC_RAM_HI = 16'h09FF;  // Secure segment last byte.

   // ******************************************************************
   // Addressing modes and sequencer states.
   // ******************************************************************
   typedef enum logic [MODE_W-1:0] {
      AM_FILE = 3'h0,
      AM_REG_DIRECT = 3'h1,
      AM_INDIRECT = 3'h2,
      AM_POST_MOD = 3'h3,
      AM_PRE_MOD = 3'h4,
      AM_INDEXED = 3'h5,
      AM_LIT_OFS = 3'h6,
      AM_LITERAL = 3'h7
   } agsc_mode_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_SECOND = 2'b10
   } agsc_state_t;

endpackage : agsc_pkg

// [core/agsc_stack_check.sv]
// Compares one stack-pointer based address against the limit and the floor.
module agsc_stack_check
   import agsc_pkg::*;
(
   input wire logic [DATA_W-1:0] addr,
   input wire logic [DATA_W-1:0] limit,
   input wire logic uses_sp,
   output logic overflow,
   output logic underflow
);

   // ******************************************************************
   // Limit comparison.
   // ******************************************************************
   // An address equal to the limit is still legal, so only strictly
   // greater addresses overflow.
   always_comb begin
      overflow = uses_sp && (addr > limit);
      underflow = uses_sp && (addr < STK_FLOOR);
   end

endmodule : agsc_stack_check

// [core/agsc_ram_guard.sv]
// Blocks access to a protected RAM window unless code runs from its segment.
module agsc_ram_guard
   import agsc_pkg::*;
(
   input wire logic [DATA_W-1:0] addr,
   input wire logic access,
   input wire logic boot_secure_ram_en,
   input wire logic secure_segment_ram_en,
   input wire logic exec_in_boot,
   input wire logic exec_in_secure,
   output logic deny
);

   logic in_boot;  // Address falls into the boot window.
   logic in_sec;  // Address falls into the secure window.

   // ******************************************************************
   // Window decode.
   // ******************************************************************
   // Both windows are closed only while their enable is set.
   always_comb begin
      in_boot = (addr >= BOOT_RAM_LO) && (addr <= BOOT_RAM_HI);
      in_sec = (addr >= SEC_RAM_LO) && (addr <= SEC_RAM_HI);
      deny = access && ((boot_secure_ram_en && in_boot && !exec_in_boot)
         || (secure_segment_ram_en && in_sec && !exec_in_secure));
   end

endmodule : agsc_ram_guard

// [core/agsc_top.sv]
// Operation
// - Stack pointer holds next free word, grows upward.
// - Push writes then increments; pop decrements then reads.
// - Call pushes upper PC with MSb cleared.
// - Exception push adds status low byte.
// - Stack limit has no reset value.
// - Stack limit bit zero always reads zero.
// - Every stack pointer address checked against limit.
// - Push at limit passes, next push traps.
// - Stack address below floor raises trap.
// - Boot secure RAM only from boot code.
// - Secure segment RAM only from secure code.
// - Direct field reaches near space only.
// - File ops default to working register zero.
// - Move reaches the whole data space.
// - Three-operand: register first, register/memory/literal second.
// - Modes include direct, indirect, modified, literals.
// - Direct uses given address; indirect uses pointer.
// - Post-modify uses pointer, then adjusts it.
// - Pre-modify adjusts pointer, then uses it.
// - Indexed adds pointer and base register.
// - Literal offset adds pointer and literal.
module agsc_top
   import agsc_pkg::*;
(
   input wire logic core_clk,
   input wire logic reset,
   // Addressing request from instruction decode.
   input wire logic req_valid,
   input wire logic [MODE_W-1:0] req_mode,
   input wire logic [SEL_W-1:0] req_ptr,
   input wire logic [SEL_W-1:0] req_base,
   input wire logic [DATA_W-1:0] req_file_addr,
   input wire logic req_is_move,
   input wire logic req_is_write,
   input wire logic [DATA_W-1:0] req_offset,
   input wire logic [LIT_W-1:0] req_lit,
   input wire logic req_lit_wide,
   input wire logic req_dest_default_working_register,
   input wire logic req_is_mul,
   input wire logic [SEL_W-1:0] req_mul_dest,
   // Stack requests.
   input wire logic stk_push,
   input wire logic [DATA_W-1:0] stk_data,
   input wire logic stk_pop,
   input wire logic pc_push,
   input wire logic pc_push_exc,
   input wire logic [PC_W-1:0] pc_value,
   input wire logic [BYTE_W-1:0] status_low_byte,
   // Writeback from execute.
   input wire logic wr_en,
   input wire logic [SEL_W-1:0] wr_sel,
   input wire logic [DATA_W-1:0] wr_data,
   input wire logic lim_wr,
   input wire logic [DATA_W-1:0] lim_data,
   // Secure RAM controls.
   input wire logic boot_secure_ram_en,
   input wire logic secure_segment_ram_en,
   input wire logic exec_in_boot,
   input wire logic exec_in_secure,
   // Results.
   output logic [DATA_W-1:0] mem_addr,
   output logic mem_rd,
   output logic mem_wr,
   output logic [DATA_W-1:0] mem_wdata,
   output logic [DATA_W-1:0] op1_data,
   output logic [DATA_W-1:0] op2_data,
   output logic [SEL_W-1:0] dest_sel,
   output logic stack_err_trap,
   output logic access_denied,
   output logic busy,
   output logic [DATA_W-1:0] stack_ptr_reg,
   output logic [DATA_W-1:0] stack_limit_reg
);

   // ******************************************************************
   // State.
   // ******************************************************************
   typedef struct packed {
      logic [NREGS-1:0][DATA_W-1:0] default_working_register;  // Working registers.
      agsc_state_t fsm;  // Push sequencer.
      logic [DATA_W-1:0] hold;  // Second word of a PC push.
      logic [DATA_W-1:0] mem_addr;
      logic mem_rd;
      logic mem_wr;
      logic [DATA_W-1:0] mem_wdata;
      logic [DATA_W-1:0] op1;
      logic [DATA_W-1:0] op2;
      logic [SEL_W-1:0] dest;
      logic trap;
      logic denied;
   } agsc_st_t;

   agsc_st_t st;  // Registered state.
   agsc_st_t next_st;  // Next state.
   logic [DATA_W-1:0] lim;  // Limit register, kept apart since it has no reset.
   logic [DATA_W-1:0] next_lim;  // Next limit value.

   agsc_mode_t mode;  // Decoded addressing mode.
   logic [DATA_W-1:0] sp;  // Current stack pointer.
   logic [DATA_W-1:0] ptr_val;  // Selected pointer register.
   logic [DATA_W-1:0] ea;  // Effective address being checked.
   logic [DATA_W-1:0] ptr_new;  // Pointer value after modification.
   logic ptr_wb;  // Pointer is written back.
   logic uses_sp;  // Address was formed from the stack pointer.
   logic mem_access;  // Request touches data memory.
   logic ovf;  // Stack limit exceeded.
   logic udf;  // Stack below the floor.
   logic deny;  // Secure window refused.
   logic push_any;  // Any push wants the idle sequencer.

   assign mode = agsc_mode_t'(req_mode);
   assign sp = st.default_working_register[SP_IDX];
   assign ptr_val = st.default_working_register[req_ptr];
   assign push_any = stk_push || pc_push;

   // ******************************************************************
   // Effective address formation.
   // ******************************************************************
   // Stack traffic has priority over the addressing request, and the
   // second word of a PC push owns the cycle after the first.
   always_comb begin
      ea = sp;
      ptr_new = ptr_val;
      ptr_wb = 1'b0;
      uses_sp = 1'b0;
      mem_access = 1'b0;
      if (st.fsm == ST_SECOND || (st.fsm == ST_IDLE && push_any)) begin
         ea = sp;
         uses_sp = 1'b1;
         mem_access = 1'b1;
      end else if (stk_pop) begin
         ea = sp - STK_STEP;
         uses_sp = 1'b1;
         mem_access = 1'b1;
      end else if (req_valid) begin
         mem_access = (mode != AM_REG_DIRECT) && (mode != AM_LITERAL);
         uses_sp = (req_ptr == SP_IDX) && mem_access && (mode != AM_FILE);
         unique case (mode)
            AM_FILE: begin
               // Only the move form reaches past the near space.
               if (req_is_move) begin
                  ea = req_file_addr;
               end else begin
                  ea = {{(DATA_W-NEAR_W){1'b0}}, req_file_addr[NEAR_W-1:0]};
               end
            end
            AM_INDIRECT: begin
               ea = ptr_val;
            end
            AM_POST_MOD: begin
               ea = ptr_val;
               ptr_new = ptr_val + req_offset;
               ptr_wb = 1'b1;
            end
            AM_PRE_MOD: begin
               ptr_new = ptr_val + req_offset;
               ea = ptr_new;
               ptr_wb = 1'b1;
            end
            AM_INDEXED: begin
               ea = ptr_val + st.default_working_register[req_base];
            end
            AM_LIT_OFS: begin
               ea = ptr_val + req_offset;
            end
            AM_REG_DIRECT, AM_LITERAL: begin
               ea = sp;
            end
         endcase
      end
   end

   agsc_stack_check u_stack_check (
      .addr(ea),
      .limit(lim),
      .uses_sp(uses_sp),
      .overflow(ovf),
      .underflow(udf)
   );

   agsc_ram_guard u_ram_guard (
      .addr(ea),
      .access(mem_access),
      .boot_secure_ram_en(boot_secure_ram_en),
      .secure_segment_ram_en(secure_segment_ram_en),
      .exec_in_boot(exec_in_boot),
      .exec_in_secure(exec_in_secure),
      .deny(deny)
   );

   // ******************************************************************
   // Next state.
   // ******************************************************************
   // A trapped or refused access leaves memory and pointers untouched,
   // so the handler sees the stack exactly as it was before the fault.
   always_comb begin
      next_st = st;
      next_st.mem_rd = 1'b0;
      next_st.mem_wr = 1'b0;
      next_st.trap = 1'b0;
      next_st.denied = 1'b0;
      // Execute writeback is overridden by a same-cycle pointer update.
      if (wr_en) begin
         next_st.default_working_register[wr_sel] = wr_data;
      end
      unique case (st.fsm)
         ST_IDLE: begin
            if (push_any || stk_pop || req_valid) begin
               next_st.mem_addr = ea;
            end
            if (push_any || stk_pop) begin
               if (ovf || udf) begin
                  next_st.trap = 1'b1;
               end else if (deny) begin
                  next_st.denied = 1'b1;
               end else if (push_any) begin
                  next_st.mem_wr = 1'b1;
                  next_st.mem_wdata = pc_push ? pc_value[DATA_W-1:0] : stk_data;
                  next_st.default_working_register[SP_IDX] = sp + STK_STEP;
                  if (pc_push) begin
                     next_st.fsm = ST_SECOND;
                     if (pc_push_exc) begin
                        next_st.hold = {status_low_byte,
                           {(BYTE_W-PC_HI_W){1'b0}}, pc_value[PC_W-1:DATA_W]};
                     end else begin
                        next_st.hold = {{(DATA_W-PC_HI_W){1'b0}},
                           pc_value[PC_W-1:DATA_W]};
                     end
                  end
               end else begin
                  next_st.mem_rd = 1'b1;
                  next_st.default_working_register[SP_IDX] = ea;
               end
            end else if (req_valid) begin
               // Three-operand source one is always a plain register.
               next_st.op1 = st.default_working_register[req_base];
               if (mode == AM_REG_DIRECT) begin
                  next_st.op2 = ptr_val;
               end else if (req_lit_wide) begin
                  next_st.op2 = {{(DATA_W-LIT_W){1'b0}}, req_lit};
               end else begin
                  next_st.op2 = {{(DATA_W-LIT5_W){1'b0}}, req_lit[LIT5_W-1:0]};
               end
               // File operations default to register zero, multiply names its own.
               if (req_dest_default_working_register) begin
                  next_st.dest = req_is_mul ? req_mul_dest : DEFAULT_WORKING_REGISTER_IDX;
               end else begin
                  next_st.dest = req_ptr;
               end
               if (ovf || udf) begin
                  next_st.trap = 1'b1;
               end else if (deny) begin
                  next_st.denied = 1'b1;
               end else begin
                  next_st.mem_rd = mem_access && !req_is_write;
                  next_st.mem_wr = mem_access && req_is_write;
                  if (ptr_wb) begin
                     next_st.default_working_register[req_ptr] = ptr_new;
                  end
               end
            end
         end
         ST_SECOND: begin
            next_st.mem_addr = ea;
            next_st.fsm = ST_IDLE;
            if (ovf || udf) begin
               next_st.trap = 1'b1;
            end else if (deny) begin
               next_st.denied = 1'b1;
            end else begin
               next_st.mem_wr = 1'b1;
               next_st.mem_wdata = st.hold;
               next_st.default_working_register[SP_IDX] = sp + STK_STEP;
            end
         end
      endcase
   end

   // ******************************************************************
   // Registers.
   // ******************************************************************
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         st <= '{fsm: ST_IDLE, default: '0};  // Sequencer idles, all else clears.
      end else begin
         st <= next_st;
      end
   end

   // The limit is left unreset on purpose; bit zero is forced clear so
   // that no odd boundary can ever be stored.
   always_comb begin
      next_lim = lim;
      if (lim_wr) begin
         next_lim = lim_data & WORD_MASK;
      end
   end

   always_ff @(posedge core_clk) begin
      lim <= next_lim;
   end

   // A stack read issued in the same cycle as a limit write still compares with
   // the old limit; software is expected not to do that.
   assign mem_addr = st.mem_addr;
   assign mem_rd = st.mem_rd;
   assign mem_wr = st.mem_wr;
   assign mem_wdata = st.mem_wdata;
   assign op1_data = st.op1;
   assign op2_data = st.op2;
   assign dest_sel = st.dest;
   assign stack_err_trap = st.trap;
   assign access_denied = st.denied;
   assign busy = (st.fsm == ST_SECOND);
   assign stack_ptr_reg = st.default_working_register[SP_IDX];
   assign stack_limit_reg = lim;

   // ******************************************************************
   // Checks.
   // ******************************************************************
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);

   chk_push_step: assert property (
      (st.fsm == ST_IDLE && stk_push && !pc_push && !ovf && !udf && !deny)
      |=> (stack_ptr_reg == $past(sp) + STK_STEP) && mem_wr && mem_addr == $past(sp))
      else $error("push did not write at pointer and step by one word");
   chk_pop_pre: assert property (
      (st.fsm == ST_IDLE && !push_any && stk_pop && !ovf && !udf && !deny)
      |=> mem_rd && mem_addr == $past(sp) - STK_STEP && stack_ptr_reg == mem_addr)
      else $error("pop did not decrement before reading");
   chk_call_msb: assert property (
      (st.fsm == ST_IDLE && pc_push && !pc_push_exc && !ovf && !udf && !deny)
      ##2 mem_wr |-> !mem_wdata[DATA_W-1])
      else $error("call push upper word has its top bit set");
   chk_exc_status: assert property (
      (st.fsm == ST_IDLE && pc_push && pc_push_exc && !ovf && !udf && !deny)
      ##2 mem_wr |-> mem_wdata[DATA_W-1:DATA_W-BYTE_W] == $past(status_low_byte, 2))
      else $error("exception push lost the status low byte");
   chk_limit_even: assert property (
      $past(lim_wr) |-> !stack_limit_reg[0])
      else $error("limit register holds an odd value");
   chk_limit_equal: assert property (
      (st.fsm == ST_IDLE && stk_push && !pc_push && sp == lim && sp >= STK_FLOOR)
      |=> !stack_err_trap)
      else $error("push at the limit trapped");
   chk_floor_trap: assert property (
      (st.fsm == ST_IDLE && !push_any && stk_pop && (sp - STK_STEP) < STK_FLOOR)
      |=> stack_err_trap && !mem_rd && stack_ptr_reg == $past(sp))
      else $error("stack below the floor did not trap");
   chk_boot_guard: assert property (
      (st.fsm == ST_IDLE && !push_any && !stk_pop && req_valid && mode == AM_FILE
      && boot_secure_ram_en && !exec_in_boot && ea >= BOOT_RAM_LO && ea <= BOOT_RAM_HI)
      |=> access_denied && !mem_rd && !mem_wr)
      else $error("boot secure RAM reached from other code");
   chk_pre_order: assert property (
      (st.fsm == ST_IDLE && !push_any && !stk_pop && req_valid && mode == AM_PRE_MOD
      && req_ptr != SP_IDX && !deny && !(wr_en && wr_sel == req_ptr))
      |=> mem_addr == $past(ptr_val) + $past(req_offset) && st.default_working_register[$past(req_ptr)] == mem_addr)
      else $error("pre-modified address not taken from updated pointer");

endmodule : agsc_top

// [testbench/agsc_mem_model.sv]
module agsc_mem_model
   import agsc_pkg::*;
(
   input wire logic core_clk,
   input wire logic mem_wr,
   input wire logic [DATA_W-1:0] mem_addr,
   input wire logic [DATA_W-1:0] mem_wdata,
   input wire logic [DATA_W-1:0] look_addr,
   output logic [DATA_W-1:0] look_data
);
   timeunit 1ns;
   timeprecision 1ns;
   // ****************************************
   // Word store seen by the execute side.
   // ****************************************
   // Words are kept by word index, so a byte address always lands on its word.
   logic [DATA_W-1:0] words [0:32767];
   // Capture every write strobe in the cycle that the block raises it.
   always_ff @(posedge core_clk) begin
      if (mem_wr) begin
         words[mem_addr[15:1]] <= mem_wdata;
      end
   end
   // Unwritten words read as unknown, so a missed write never passes a compare.
   assign look_data = words[look_addr[15:1]];
endmodule : agsc_mem_model

// [testbench/address_gen_stack_check_test.sv]
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin err_total++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module address_gen_stack_check_test;
   import agsc_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic core_clk, reset, req_valid, req_is_move, req_is_write, req_lit_wide, req_dest_default_working_register;
   logic req_is_mul, stk_push, stk_pop, pc_push, pc_push_exc, wr_en, lim_wr, boot_secure_ram_en;
   logic secure_segment_ram_en, exec_in_boot, exec_in_secure, mem_rd, mem_wr, stack_err_trap;
   logic access_denied, busy;
   logic [2:0] req_mode;
   logic [3:0] req_ptr, req_base, req_mul_dest, wr_sel, dest_sel;
   logic [15:0] req_file_addr, req_offset, stk_data, wr_data, lim_data, mem_addr, mem_wdata;
   logic [15:0] op1_data, op2_data, stack_ptr_reg, stack_limit_reg, look_addr, look_data;
   logic [9:0] req_lit;
   logic [22:0] pc_value;
   logic [7:0] status_low_byte;
   int err_total = 0;
   int cmp_count = 0;
   agsc_top dut (.*);
   agsc_mem_model mem (.core_clk(core_clk), .mem_wr(mem_wr), .mem_addr(mem_addr),
      .mem_wdata(mem_wdata), .look_addr(look_addr), .look_data(look_data));
   // ****************************************
   // Clock and drivers.
   // ****************************************
   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end
   // Writeback to one working register; it lands at the second edge.
   task automatic default_working_register(input logic [3:0] s, input logic [15:0] d);
      @(posedge core_clk);
      wr_en <= 1'b1;
      wr_sel <= s;
      wr_data <= d;
      @(posedge core_clk);
      wr_en <= 1'b0;
      @(negedge core_clk);
   endtask : default_working_register
   // lim_wr drops before the next request is driven, so the new limit is settled.
   task automatic lim(input logic [15:0] d);
      @(posedge core_clk);
      lim_wr <= 1'b1;
      lim_data <= d;
      @(posedge core_clk);
      lim_wr <= 1'b0;
      @(negedge core_clk);
   endtask : lim
   // Flags f are {move, write, to working register, multiply}.
   task automatic req(input logic [2:0] m, input logic [3:0] p, input logic [3:0] b,
                      input logic [15:0] a, input logic [15:0] o, input logic [3:0] f);
      @(posedge core_clk);
      req_valid <= 1'b1;
      req_mode <= m;
      req_ptr <= p;
      req_base <= b;
      req_file_addr <= a;
      req_offset <= o;
      {req_is_move, req_is_write, req_dest_default_working_register, req_is_mul} <= f;
      @(posedge core_clk);
      req_valid <= 1'b0;
      @(negedge core_clk);
   endtask : req
   // Stack kinds k are {exception, pc push, pop, push}; results are read one cycle later.
   task automatic stk(input logic [3:0] k, input logic [15:0] d);
      @(posedge core_clk);
      {pc_push_exc, pc_push, stk_pop, stk_push} <= k;
      stk_data <= d;
      @(posedge core_clk);
      {pc_push_exc, pc_push, stk_pop, stk_push} <= 4'h0;
      @(negedge core_clk);
   endtask : stk
   task automatic finish_test();
      $display("compares %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : finish_test
   // ****************************************
   // Scenarios.
   // ****************************************
   task automatic t_stack();
      lim(16'h0901);
      `CHK(stack_limit_reg, 16'h0900)
      default_working_register(4'hF, 16'h08FC);
      stk(4'h1, 16'h1111);
      `CHK(mem_wr, 1'b1)
      `CHK(mem_addr, 16'h08FC)
      `CHK(stack_ptr_reg, 16'h08FE)
      stk(4'h1, 16'h2222);
      stk(4'h1, 16'h3333);
      `CHK(stack_err_trap, 1'b0)
      `CHK(mem_addr, 16'h0900)
      stk(4'h1, 16'h4444);
      `CHK(stack_err_trap, 1'b1)
      `CHK(mem_wr, 1'b0)
      `CHK(stack_ptr_reg, 16'h0902)
      stk(4'h2, 16'h0000);
      `CHK(mem_rd, 1'b1)
      `CHK(mem_addr, 16'h0900)
      `CHK(stack_ptr_reg, 16'h0900)
      default_working_register(4'hF, 16'h0800);
      stk(4'h2, 16'h0000);
      `CHK(stack_err_trap, 1'b1)
      `CHK(stack_ptr_reg, 16'h0800)
   endtask : t_stack
   // A call push and an exception push; the upper word differs only in its high byte.
   task automatic t_pc(input logic [3:0] k, input logic [15:0] s, input logic [15:0] hi);
      int n;
      @(posedge core_clk);
      pc_value <= 23'h5A1234;
      stk(k, 16'h0000);
      `CHK(mem_wdata, 16'h1234)
      `CHK(busy, 1'b1)
      for (n = 0; n < 4 && busy !== 1'b0; n++) begin
         @(negedge core_clk);
      end
      if (n == 4) begin
         err_total++;
         finish_test();
      end
      look_addr <= s + 16'h0002;
      @(negedge core_clk);
      `CHK(look_data, hi)
      `CHK(stack_ptr_reg, s + 16'h0004)
   endtask : t_pc
   task automatic t_modes();
      default_working_register(4'h1, 16'h1000);
      default_working_register(4'h2, 16'h0010);
      req(3'h3, 4'h1, 4'h0, 16'h0000, 16'h0002, 4'h0);
      `CHK(mem_addr, 16'h1000)
      req(3'h2, 4'h1, 4'h0, 16'h0000, 16'h0000, 4'h4);
      `CHK(mem_addr, 16'h1002)
      `CHK(mem_wr, 1'b1)
      req(3'h4, 4'h1, 4'h0, 16'h0000, 16'hFFFE, 4'h0);
      `CHK(mem_addr, 16'h1000)
      req(3'h5, 4'h1, 4'h2, 16'h0000, 16'h0000, 4'h2);
      `CHK(mem_addr, 16'h1010)
      `CHK(dest_sel, 4'h0)
      req(3'h6, 4'h1, 4'h0, 16'h0000, 16'h0004, 4'h3);
      `CHK(mem_addr, 16'h1004)
      `CHK(dest_sel, 4'h6)
      req(3'h0, 4'h0, 4'h0, 16'hFFFF, 16'h0000, 4'h0);
      `CHK(mem_addr, 16'h1FFF)
      req(3'h0, 4'h0, 4'h0, 16'hFFFF, 16'h0000, 4'h8);
      `CHK(mem_addr, 16'hFFFF)
      req(3'h1, 4'h1, 4'h2, 16'h0000, 16'h0000, 4'h0);
      `CHK({op1_data, op2_data}, 32'h0010_1000)
      req(3'h7, 4'h1, 4'h2, 16'h0000, 16'h0000, 4'h0);
      `CHK(op2_data, 16'h03A5)
      @(posedge core_clk);
      req_lit_wide <= 1'b0;
      req(3'h7, 4'h1, 4'h2, 16'h0000, 16'h0000, 4'h0);
      `CHK(op2_data, 16'h0005)
   endtask : t_modes
   // Each window is refused from foreign code and opened from its own segment.
   task automatic t_secure(input logic [15:0] a, input logic [1:0] en, input logic [1:0] ex);
      @(posedge core_clk);
      {boot_secure_ram_en, secure_segment_ram_en} <= en;
      {exec_in_boot, exec_in_secure} <= ~ex;
      req(3'h0, 4'h0, 4'h0, a, 16'h0000, 4'h0);
      `CHK({access_denied, mem_rd}, 2'b10)
      @(posedge core_clk);
      {exec_in_boot, exec_in_secure} <= ex;
      req(3'h0, 4'h0, 4'h0, a, 16'h0000, 4'h0);
      `CHK({access_denied, mem_rd}, 2'b01)
   endtask : t_secure
   initial begin
      {req_valid, req_is_move, req_is_write, req_dest_default_working_register, req_is_mul, stk_push, stk_pop} = '0;
      {pc_push, pc_push_exc, wr_en, lim_wr, boot_secure_ram_en, secure_segment_ram_en} = '0;
      {exec_in_boot, exec_in_secure, req_mode, req_ptr, req_base, wr_sel, look_addr} = '0;
      {req_file_addr, req_offset, stk_data, wr_data, lim_data, pc_value} = '0;
      req_lit = 10'h3A5;
      req_lit_wide = 1'b1;
      req_mul_dest = 4'h6;
      status_low_byte = 8'hC3;
      reset = 1'b1;
      repeat (3) @(posedge core_clk);
      reset <= 1'b0;
      t_stack();
      lim(16'h1FFE);
      default_working_register(4'hF, 16'h0A00);
      t_pc(4'h4, 16'h0A00, 16'h005A);
      t_pc(4'hC, 16'h0A04, 16'hC35A);
      t_modes();
      t_secure(16'h0810, 2'b10, 2'b10);
      t_secure(16'h0910, 2'b01, 2'b01);
      finish_test();
   end
endmodule : address_gen_stack_check_test
